//--- spc_defs.svh
// Purpose: Register offsets, field positions and reset values for the stop-mode power controller
// Assumes: APB word-aligned registers, 32-bit data
// Notes:   Definitions only
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SPC_ADDR_CTRL     12'h000
`define SPC_ADDR_PERIPH   12'h004
`define SPC_ADDR_STATUS   12'h008
`define SPC_ADDR_DEBUG    12'h00C

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SPC_CTRL_STOPEN   0
`define SPC_CTRL_LOW_VOLTAGE_DETECT_ENABLE     1
`define SPC_CTRL_LVSE     2
`define SPC_CTRL_PPDSEL   3
`define SPC_CTRL_PARTIAL_POWERDOWN_ACK   4
`define SPC_CTRL_DBGEN    5
`define SPC_CTRL_RST      6'h00

// ----------------------------------------
// Peripheral option register fields
// ----------------------------------------
`define SPC_PER_ADCLK     0
`define SPC_PER_CMPBG     1
`define SPC_PER_IRCEN     2
`define SPC_PER_IRSEN     3
`define SPC_PER_ERCEN     4
`define SPC_PER_ERSEN     5
`define SPC_PER_XRANGE    6
`define SPC_PER_USB_MODULE_ENABLE     7
`define SPC_PER_PHYEN     8
`define SPC_PER_RTCIE     9
`define SPC_PER_PS_LSB    12
`define SPC_PER_RST       16'h0000

// ----------------------------------------
// Debug status codes
// ----------------------------------------
`define SPC_DBG_OK        2'h0
`define SPC_DBG_ERR_STOP  2'h1

`endif

//--- spc_pkg.sv
// Purpose: Types for the stop-mode power controller
// Assumes: Nothing beyond the defs header
// Notes:   Types only
package spc_pkg;

   typedef enum logic [2:0] {
      SPC_RUN,
      SPC_SHALLOW,
      SPC_DEEP,
      SPC_DEEP_WAKE,
      SPC_BKGND
   } spc_state_e;

   // Power domain enables for optional peripherals
   typedef struct packed {
      logic adc_on;
      logic cmp_on;
      logic irc_on;
      logic crystal_oscillator_on;
      logic rtc_on;
      logic usb_on;
   } spc_periph_s;

   // Core-facing power controls
   typedef struct packed {
      logic regulator_full;
      logic debug_clk_on;
      logic periph_clk_on;
      logic core_power_on;
      logic pin_latch_hold;
      logic lvr_low_trip;
   } spc_power_s;

endpackage

//--- spc_ctrl.sv
// Purpose: Stop-mode power controller: mode choice, clock gating, pin latches, wake handling
// Assumes: Single clock pclk at 125 MHz; APB slave; inputs synchronous except wake pins
// Notes:   Wake pins are synchronised in two flops before they can release a stop state
`include "spc_defs.svh"

module spc_ctrl #(
   parameter int PS_W = 4
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               clk_en,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   // CPU core
   input  wire logic               stop_exec,
   input  wire logic               irq_wake_pend,
   output logic                    illegal_op_reset,
   output logic                    reset_vector_fetch,
   output logic                    irq_vector_take,
   output logic                    module_reset,
   // Wake pins and counter
   input  wire logic               reset_pin_n,
   input  wire logic               wake_interrupt_pin_n,
   input  wire logic               rtc_irq,
   // Debug host
   input  wire logic               dbg_bkgnd_cmd,
   input  wire logic               dbg_memstat_cmd,
   output logic                    dbg_mem_access,
   output logic [1:0]              dbg_status,
   output logic                    bkgnd_active,
   // Power controls
   output spc_pkg::spc_power_s     power,
   output spc_pkg::spc_periph_s    periph
);

   // ----------------------------------------
   // Registers and state
   // ----------------------------------------
   logic [5:0]             ctrl;
   logic [15:0]            popt;
   logic                   partial_powerdown_flag;
   spc_pkg::spc_state_e    state;
   logic                   rtc_keep;
   logic [1:0]             rst_sync;
   logic [1:0]             irq_sync;
   logic [1:0]             rtc_sync;

   logic                   stop_instruction_enable;
   logic                   low_voltage_detect_enable;
   logic                   low_voltage_stop_enable;
   logic                   partial_powerdown_select;
   logic                   debug_mode_enable;
   logic                   lvd_in_stop;
   logic                   wr_en;
   logic                   rd_en;
   logic                   stopped;
   logic                   wake_reset;
   logic                   wake_irq;
   logic                   wake_rtc;

   assign stop_instruction_enable   = ctrl[`SPC_CTRL_STOPEN];
   assign low_voltage_detect_enable = ctrl[`SPC_CTRL_LOW_VOLTAGE_DETECT_ENABLE];
   assign low_voltage_stop_enable   = ctrl[`SPC_CTRL_LVSE];
   assign partial_powerdown_select  = ctrl[`SPC_CTRL_PPDSEL];
   assign debug_mode_enable         = ctrl[`SPC_CTRL_DBGEN];
   assign lvd_in_stop = low_voltage_detect_enable & low_voltage_stop_enable;
   assign wr_en = psel & penable & pwrite & clk_en;
   assign rd_en = psel & ~penable & ~pwrite & clk_en;
   assign stopped = (state == spc_pkg::SPC_SHALLOW) || (state == spc_pkg::SPC_DEEP);

   // ----------------------------------------
   // Wake synchronisers
   // ----------------------------------------
   // Two flops per wake source; only the second flop is read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_sync <= 2'h0;
         irq_sync <= 2'h0;
         rtc_sync <= 2'h0;
      end else if (clk_en) begin
         rst_sync <= {rst_sync[0], ~reset_pin_n};
         irq_sync <= {irq_sync[0], ~wake_interrupt_pin_n};
         rtc_sync <= {rtc_sync[0], rtc_irq};
      end
   end

   assign wake_reset = rst_sync[1];
   assign wake_irq   = irq_sync[1];  // Active-low pin, any prior config
   assign wake_rtc   = rtc_sync[1] & popt[`SPC_PER_RTCIE];

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   // Deep wake clears module registers as a power-on would
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `SPC_CTRL_RST;
         popt <= `SPC_PER_RST;
      end else if (clk_en) begin
         if (state == spc_pkg::SPC_DEEP_WAKE) begin
            ctrl <= `SPC_CTRL_RST;
            popt <= `SPC_PER_RST;
         end else if (wr_en && paddr == `SPC_ADDR_CTRL) begin
            ctrl <= pwdata[5:0] & 6'h2F;                   // Ack bit is write-only
         end else if (wr_en && paddr == `SPC_ADDR_PERIPH) begin
            popt <= pwdata[15:0];
         end
      end
   end

   // ----------------------------------------
   // Partial powerdown flag
   // ----------------------------------------
   // Set wins over a simultaneous acknowledge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         partial_powerdown_flag <= 1'b0;
      end else if (clk_en) begin
         if (state == spc_pkg::SPC_DEEP_WAKE) begin
            partial_powerdown_flag <= 1'b1;
         end else if (wr_en && paddr == `SPC_ADDR_CTRL && pwdata[`SPC_CTRL_PARTIAL_POWERDOWN_ACK]) begin
            partial_powerdown_flag <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Stop state machine
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state    <= spc_pkg::SPC_RUN;
         rtc_keep <= 1'b0;
      end else if (clk_en) begin
         case (state)
            spc_pkg::SPC_RUN, spc_pkg::SPC_BKGND: begin
               if (stop_exec && stop_instruction_enable) begin
                  rtc_keep <= |popt[`SPC_PER_PS_LSB +: PS_W];
                  if (partial_powerdown_select && !debug_mode_enable && !lvd_in_stop) begin
                     state <= spc_pkg::SPC_DEEP;
                  end else begin
                     state <= spc_pkg::SPC_SHALLOW;
                  end
               end
            end
            spc_pkg::SPC_SHALLOW: begin
               if (wake_reset || irq_wake_pend || wake_rtc) begin
                  state <= spc_pkg::SPC_RUN;
               end else if (dbg_bkgnd_cmd && debug_mode_enable) begin
                  state <= spc_pkg::SPC_BKGND;
               end
            end
            spc_pkg::SPC_DEEP: begin
               if (wake_reset || wake_irq || wake_rtc) begin
                  state <= spc_pkg::SPC_DEEP_WAKE;
               end
            end
            spc_pkg::SPC_DEEP_WAKE: begin
               state <= spc_pkg::SPC_RUN;
            end
            default: begin
               state <= spc_pkg::SPC_RUN;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Core events
   // ----------------------------------------
   // One-cycle pulses toward the core
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         illegal_op_reset   <= 1'b0;
         reset_vector_fetch <= 1'b0;
         irq_vector_take    <= 1'b0;
         module_reset       <= 1'b0;
      end else if (clk_en) begin
         illegal_op_reset   <= (state == spc_pkg::SPC_RUN || state == spc_pkg::SPC_BKGND)
                               && stop_exec && !stop_instruction_enable;
         reset_vector_fetch <= (state == spc_pkg::SPC_DEEP_WAKE)
                               || (state == spc_pkg::SPC_SHALLOW && wake_reset);
         irq_vector_take    <= state == spc_pkg::SPC_SHALLOW && !wake_reset
                               && (irq_wake_pend || wake_rtc);
         module_reset       <= state == spc_pkg::SPC_DEEP_WAKE;
      end
   end

   // ----------------------------------------
   // Debug host answers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dbg_mem_access <= 1'b0;
         dbg_status     <= `SPC_DBG_OK;
         bkgnd_active   <= 1'b0;
      end else if (clk_en) begin
         dbg_mem_access <= dbg_memstat_cmd && !stopped;
         if (dbg_memstat_cmd) begin
            dbg_status <= stopped ? `SPC_DBG_ERR_STOP : `SPC_DBG_OK;
         end
         bkgnd_active   <= state == spc_pkg::SPC_BKGND;
      end
   end

   // ----------------------------------------
   // Power and clock controls
   // ----------------------------------------
   // Regulator and debug clock choices hold through shallow stop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power <= '{regulator_full: 1'b1, debug_clk_on: 1'b1, periph_clk_on: 1'b1,
                    core_power_on: 1'b1, pin_latch_hold: 1'b0, lvr_low_trip: 1'b0};
      end else if (clk_en) begin
         power.regulator_full <= !stopped || lvd_in_stop || debug_mode_enable;
         power.debug_clk_on   <= !stopped || debug_mode_enable;
         power.periph_clk_on  <= !stopped;
         power.core_power_on  <= state != spc_pkg::SPC_DEEP;
         // Latches close on deep entry and open only on acknowledge
         // The wake cycle holds them too, so they never open before the flag is set
         power.pin_latch_hold <= state == spc_pkg::SPC_DEEP || state == spc_pkg::SPC_DEEP_WAKE
                                 || (partial_powerdown_flag && !(wr_en && paddr == `SPC_ADDR_CTRL
                                                                 && pwdata[`SPC_CTRL_PARTIAL_POWERDOWN_ACK]))
                                 || (stop_exec && state == spc_pkg::SPC_RUN && stop_instruction_enable
                                     && partial_powerdown_select && !debug_mode_enable
                                     && !lvd_in_stop);
         if (state == spc_pkg::SPC_DEEP_WAKE) begin
            power.lvr_low_trip <= 1'b1;
         end else if (wr_en && paddr == `SPC_ADDR_CTRL) begin
            power.lvr_low_trip <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Optional peripherals in stop
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         periph <= '0;
      end else if (clk_en) begin
         if (state == spc_pkg::SPC_SHALLOW) begin
            periph.adc_on  <= popt[`SPC_PER_ADCLK] && lvd_in_stop;
            periph.cmp_on  <= !popt[`SPC_PER_CMPBG] || lvd_in_stop;
            periph.irc_on  <= popt[`SPC_PER_IRCEN] && popt[`SPC_PER_IRSEN];
            periph.crystal_oscillator_on <= popt[`SPC_PER_ERCEN] && popt[`SPC_PER_ERSEN]
                              && (!popt[`SPC_PER_XRANGE] || lvd_in_stop);
            periph.rtc_on  <= rtc_keep;
            periph.usb_on  <= popt[`SPC_PER_USB_MODULE_ENABLE] && popt[`SPC_PER_PHYEN];
         end else if (state == spc_pkg::SPC_DEEP) begin
            periph         <= '0;
            periph.rtc_on  <= rtc_keep;
         end else begin
            periph         <= '1;                                                  // Run: all on
         end
      end
   end

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   // Zero wait states; unmapped reads return zero with an error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & !(paddr == `SPC_ADDR_CTRL || paddr == `SPC_ADDR_PERIPH
                    || paddr == `SPC_ADDR_STATUS || paddr == `SPC_ADDR_DEBUG);
         if (rd_en) begin
            case (paddr)
               `SPC_ADDR_CTRL:   prdata <= {26'h000_0000, ctrl};
               `SPC_ADDR_PERIPH: prdata <= {16'h0000, popt};
               `SPC_ADDR_STATUS: prdata <= {25'h000_0000, power.lvr_low_trip, power.pin_latch_hold,
                                            1'b0, state, partial_powerdown_flag};
               `SPC_ADDR_DEBUG:  prdata <= {30'h0000_0000, dbg_status};
               default:          prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule

//--- spc_far_end.sv
// Purpose: Far-side model of the wake pins and the counter interrupt line
// Assumes: Bench raises the pull requests just after a rising pclk edge
// Notes:   Pins carry pull-ups, so a released pin reads high
module spc_far_end (
   input  wire logic pull_reset,
   input  wire logic pull_wake,
   input  wire logic rtc_fire,
   output logic      reset_pin_n,
   output logic      wake_interrupt_pin_n,
   output logic      rtc_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Pin levels
   // ----------------------------------------
   // Released pins go to the pull-up level, never to the last driven value
   assign reset_pin_n          = !pull_reset;
   assign wake_interrupt_pin_n = !pull_wake;
   // Counter interrupt held as a level while the bench asks for it
   assign rtc_irq              = rtc_fire;
endmodule

//--- spc_ctrl_sva.sv
// Purpose: Concurrent checks on the stop-mode power controller ports
// Assumes: One pclk domain, presetn asynchronous active low
// Notes:   Stop-enable shadow follows APB writes and clears on module reset
`include "spc_defs.svh"
module spc_ctrl_sva #(
   parameter int PS_W = 4
) (
   input wire logic                 pclk,
   input wire logic                 presetn,
   input wire logic                 clk_en,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [11:0]          paddr,
   input wire logic [31:0]          pwdata,
   input wire logic [31:0]          prdata,
   input wire logic                 pready,
   input wire logic                 pslverr,
   input wire logic                 stop_exec,
   input wire logic                 illegal_op_reset,
   input wire logic                 reset_vector_fetch,
   input wire logic                 module_reset,
   input wire logic                 wake_interrupt_pin_n,
   input wire logic                 dbg_memstat_cmd,
   input wire logic                 dbg_mem_access,
   input wire logic [1:0]           dbg_status,
   input wire spc_pkg::spc_power_s  power,
   input wire spc_pkg::spc_periph_s periph
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // Helper logic
   // ----------------------------------------
   logic stop_en_sh;
   wire  ctrl_wr = psel && penable && pwrite && pready && (paddr == `SPC_ADDR_CTRL);
   wire  ack_wr  = ctrl_wr && pwdata[4]; // Acknowledge bit of the control word
   // Shadow of the stop enable; a deep wake clears the control register too
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_en_sh <= 1'b0;
      end else if (module_reset) begin
         stop_en_sh <= 1'b0;
      end else if (ctrl_wr) begin
         stop_en_sh <= pwdata[`SPC_CTRL_STOPEN];
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_illegal;
      stop_exec && clk_en && power.periph_clk_on && !stop_en_sh |=> illegal_op_reset;
   endproperty
   a_illegal: assert property (p_illegal) else $error("stop with stop disabled gave no reset");
   property p_no_stop;
      stop_exec && clk_en && power.periph_clk_on && !stop_en_sh |-> ##[1:3] power.periph_clk_on;
   endproperty
   a_no_stop: assert property (p_no_stop) else $error("disabled stop halted the clocks");
   property p_clk_halt;
      stop_exec && clk_en && power.periph_clk_on && stop_en_sh |-> ##[1:3] !power.periph_clk_on;
   endproperty
   a_clk_halt: assert property (p_clk_halt) else $error("peripheral clocks kept in stop");
   property p_dbg_reg;
      power.debug_clk_on && !power.periph_clk_on |-> power.regulator_full;
   endproperty
   a_dbg_reg: assert property (p_dbg_reg) else $error("debug clocks without full regulation");
   property p_latch;
      $rose(power.pin_latch_hold) |=> !power.core_power_on;
   endproperty
   a_latch: assert property (p_latch) else $error("pin latch set outside deep stop");
   property p_hold;
      power.pin_latch_hold && !ack_wr |=> power.pin_latch_hold;
   endproperty
   a_hold: assert property (p_hold) else $error("pin latch opened without acknowledge");
   property p_deep_off;
      !power.core_power_on |-> !(periph.adc_on || periph.cmp_on || periph.irc_on || periph.crystal_oscillator_on || periph.usb_on);
   endproperty
   a_deep_off: assert property (p_deep_off) else $error("optional block on in deep stop");
   property p_memstat;
      dbg_memstat_cmd && !power.periph_clk_on |=> !dbg_mem_access && (dbg_status == `SPC_DBG_ERR_STOP);
   endproperty
   a_memstat: assert property (p_memstat) else $error("debug access in stop not refused");
   property p_sync;
      $fell(wake_interrupt_pin_n) && !power.core_power_on |=> (!power.core_power_on) [*2];
   endproperty
   a_sync: assert property (p_sync) else $error("wake released before synchronising");
   property p_deep_exit;
      !power.core_power_on && !wake_interrupt_pin_n |-> ##[1:8] reset_vector_fetch;
   endproperty
   a_deep_exit: assert property (p_deep_exit) else $error("wake pin did not end deep stop");
   property p_unmapped;
      psel && penable && pready && (paddr > `SPC_ADDR_DEBUG) |-> pslverr && (prdata == 32'h0000_0000);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   c_deep: cover property ($rose(power.pin_latch_hold));
   c_illegal: cover property (illegal_op_reset);
   c_memstat: cover property (dbg_memstat_cmd && !power.periph_clk_on);
endmodule

bind spc_ctrl spc_ctrl_sva #(.PS_W(PS_W)) u_sva (
   .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .stop_exec(stop_exec), .illegal_op_reset(illegal_op_reset),
   .reset_vector_fetch(reset_vector_fetch), .module_reset(module_reset),
   .wake_interrupt_pin_n(wake_interrupt_pin_n), .dbg_memstat_cmd(dbg_memstat_cmd),
   .dbg_mem_access(dbg_mem_access), .dbg_status(dbg_status), .power(power), .periph(periph)
);

//--- stop_mode_power_controller_tb_top.sv
// Purpose: Directed bench for the stop-mode power controller
// Assumes: APB answers with one wait-free access cycle, status polled for mode
// Notes:   Five stop cases cover every mode choice and every wake source
`include "spc_defs.svh"
module stop_mode_power_controller_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn, clk_en, psel, penable, pwrite, stop_exec, irq_wake_pend;
   logic dbg_bkgnd_cmd, dbg_memstat_cmd, pull_reset, pull_wake, rtc_fire;
   logic illegal_op_reset, reset_vector_fetch, irq_vector_take, module_reset, pready, pslverr;
   logic reset_pin_n, wake_interrupt_pin_n, rtc_irq, dbg_mem_access, bkgnd_active;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [1:0]  dbg_status;
   logic [3:0]  pv;
   spc_pkg::spc_power_s  power;
   spc_pkg::spc_periph_s periph;
   int fails = 0;
   int check_count = 0;
   int pc [4] = '{0, 0, 0, 0};
   int snap [4];
   // Stop cases: control word, options, mode, power and option outputs, wake pulse
   logic [31:0] c_ctrl [5] = '{32'h0000_0001, 32'h0000_000F, 32'h0000_0029, 32'h0000_0009, 32'h0000_0009};
   logic [31:0] c_per [5]  = '{32'h0000_0000, 32'h0000_13FF, 32'h0000_13FF, 32'h0000_1200, 32'h0000_0000};
   logic [2:0]  c_st [5]   = '{3'h1, 3'h1, 3'h1, 3'h2, 3'h2};
   logic [5:0]  c_pow [5]  = '{6'h04, 6'h24, 6'h34, 6'h02, 6'h02};
   logic [5:0]  c_on [5]   = '{6'h10, 6'h3F, 6'h0B, 6'h02, 6'h00};
   int          c_pul [5]  = '{1, 2, 0, 3, 3};

   spc_ctrl #(.PS_W(4)) dut (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .stop_exec(stop_exec), .irq_wake_pend(irq_wake_pend),
      .illegal_op_reset(illegal_op_reset), .reset_vector_fetch(reset_vector_fetch),
      .irq_vector_take(irq_vector_take), .module_reset(module_reset), .reset_pin_n(reset_pin_n),
      .wake_interrupt_pin_n(wake_interrupt_pin_n), .rtc_irq(rtc_irq), .dbg_bkgnd_cmd(dbg_bkgnd_cmd),
      .dbg_memstat_cmd(dbg_memstat_cmd), .dbg_mem_access(dbg_mem_access), .dbg_status(dbg_status),
      .bkgnd_active(bkgnd_active), .power(power), .periph(periph)
   );
   spc_far_end far (
      .pull_reset(pull_reset), .pull_wake(pull_wake), .rtc_fire(rtc_fire), .reset_pin_n(reset_pin_n),
      .wake_interrupt_pin_n(wake_interrupt_pin_n), .rtc_irq(rtc_irq)
   );
   // ----------------------------------------
   // Clock, pulse counters and helpers
   // ----------------------------------------
   always #4 pclk = ~pclk;
   // Count the single-cycle pulses so a case can tell exactly one was given
   assign pv = {module_reset, irq_vector_take, reset_vector_fetch, illegal_op_reset};
   always @(posedge pclk) begin
      for (int k = 0; k < 4; k++) if (pv[k] === 1'b1) pc[k]++;
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One APB transfer; the request stands until pready is seen high at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      // One idle edge first: psel is never driven twice in a step
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         fails++;
         give_verdict();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      check(what, r, exp);
   endtask
   // Status word: flag, mode, latch hold, low trip
   function automatic logic [31:0] st(input logic [2:0] s, input logic f, input logic l, input logic v);
      return {25'h0, v, l, 1'b0, s, f};
   endfunction
   // Poll the mode field under a bounded count
   task automatic wait_state(input logic [2:0] s);
      logic [31:0] r;
      logic e;
      int n;
      n = 0;
      do begin
         apb(1'b0, `SPC_ADDR_STATUS, 32'h0000_0000, r, e);
         n++;
      end while (r[3:1] !== s && n < 30);
      if (n >= 30) begin
         fails++;
         give_verdict();
      end
   endtask
   task automatic do_stop();
      stop_exec <= 1'b1;
      @(posedge pclk);
      stop_exec <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [31:0] r;
      logic e;
      {presetn, psel, penable, pwrite, stop_exec, irq_wake_pend, dbg_bkgnd_cmd} = 7'h00;
      {dbg_memstat_cmd, pull_reset, pull_wake, rtc_fire} = 4'h0;
      clk_en = 1'b1;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_chk("status at reset", `SPC_ADDR_STATUS, 32'h0000_0000);
      apb(1'b0, 12'h010, 32'h0000_0000, r, e);
      check("unmapped error", {31'h0, e}, 32'h0000_0001);
      check("unmapped data", r, 32'h0000_0000);
      wr(`SPC_ADDR_CTRL, 32'h0000_0000);
      snap = pc;
      do_stop();
      check("illegal reset", pc[0] - snap[0], 1);
      rd_chk("no stop state", `SPC_ADDR_STATUS, 32'h0000_0000);
      for (int i = 0; i < 5; i++) begin
         wr(`SPC_ADDR_PERIPH, c_per[i]);
         wr(`SPC_ADDR_CTRL, c_ctrl[i]);
         snap = pc;
         do_stop();
         rd_chk("stop mode", `SPC_ADDR_STATUS, st(c_st[i], i == 4, c_st[i] == 3'h2, 1'b0));
         check("power", {26'h0, power}, {26'h0, c_pow[i]});
         check("options", {26'h0, periph}, {26'h0, c_on[i]});
         case (i)
            0: pull_reset <= 1'b1;
            1: irq_wake_pend <= 1'b1;
            2: begin
               dbg_memstat_cmd <= 1'b1;
               @(posedge pclk);
               dbg_memstat_cmd <= 1'b0;
               repeat (2) @(posedge pclk);
               check("debug status", {30'h0, dbg_status}, {30'h0, `SPC_DBG_ERR_STOP});
               dbg_bkgnd_cmd <= 1'b1;
            end
            3: rtc_fire <= 1'b1;
            default: pull_wake <= 1'b1;
         endcase
         repeat (4) @(posedge pclk);
         {pull_reset, irq_wake_pend, dbg_bkgnd_cmd, rtc_fire, pull_wake} <= 5'h00;
         wait_state((i == 2) ? 3'h4 : 3'h0);
         if (i == 2) check("background", {31'h0, bkgnd_active}, 32'h0000_0001);
         else check("wake pulse", pc[c_pul[i]] - snap[c_pul[i]], 1);
         if (i >= 3) check("reset vector", pc[1] - snap[1], 1);
      end
      rd_chk("ctrl after wake", `SPC_ADDR_CTRL, 32'h0000_0000);
      rd_chk("options after wake", `SPC_ADDR_PERIPH, 32'h0000_0000);
      rd_chk("flag after wake", `SPC_ADDR_STATUS, st(3'h0, 1'b1, 1'b1, 1'b1));
      wr(`SPC_ADDR_CTRL, 32'h0000_0000);
      rd_chk("zero ack", `SPC_ADDR_STATUS, st(3'h0, 1'b1, 1'b1, 1'b0));
      // Port registers count as restored here, before the acknowledge write
      wr(`SPC_ADDR_CTRL, 32'h0000_0010);
      rd_chk("flag after ack", `SPC_ADDR_STATUS, 32'h0000_0000);
      check("power after ack", {26'h0, power}, 32'h0000_003C);
      give_verdict();
   end
endmodule
